/* capture_match_timer_map.svh */
// register offsets, field positions, reset values and timing counts of the capture/match timer
// What this block does
// - 32-bit prescale counter advances a 32-bit timer counter, both on timer clock ticks.
// - prescale division value is fully programmable over 32 bits.
// - four capture channels store the timer count on an input change, optional interrupt.
// - four 32-bit match registers compared with the count; equality is a match event.
// - continuous mode: match leaves counting undisturbed, optional interrupt.
// - stop-on-match halts the timer, optional interrupt.
// - reset-on-match returns the timer count to zero, optional interrupt.
// - each match output goes low, high, toggles or holds on its match.
// - register access is on the bus clock, separate from the counter clock rate.
// - pause input suspends counting when asserted.
`ifndef CAPTURE_MATCH_TIMER_MAP_SVH
`define CAPTURE_MATCH_TIMER_MAP_SVH

`define REG_CTRL            8'h00
`define REG_TIMER_COUNT     8'h04
`define REG_PRESCALE        8'h08
`define REG_PRESCALE_COUNT  8'h0C
`define REG_MATCH_CFG       8'h10
`define REG_OUTPUT_CFG      8'h14
`define REG_OUTPUT_LEVEL    8'h18
`define REG_CAPTURE_CFG     8'h1C
`define REG_INT_STATUS      8'h40
`define REG_INT_MASK        8'h44
`define REG_MATCH_BLOCK     4'h2
`define REG_CAPTURE_BLOCK   4'h3

`define CTRL_ENABLE_BIT     0
`define CTRL_CLEAR_BIT      1
`define CTRL_PAUSE_EN_BIT   2
`define CFG_W               3
`define MCFG_IRQ            0
`define MCFG_STOP           1
`define MCFG_RESET          2
`define CCFG_RISE           0
`define CCFG_FALL           1
`define CCFG_IRQ            2
`define OCFG_W              2
`define ST_CAPTURE_LSB      4

`define CTRL_RESET          3'h0
`define COUNT_RESET         32'h0
`define CFG_RESET           12'h000
`define OCFG_RESET          8'h00
`define LEVEL_RESET         4'h0
`define FLAG_RESET          8'h00

`define TICK_DIV_LAST       4'h1

`endif

/* capture_match_timer_pkg.sv */
// types shared by the capture/match timer modules
`default_nettype none
package capture_match_timer_pkg;
	typedef enum logic [1:0] {
		ACT_NOTHING = 2'b00,
		ACT_LOW     = 2'b01,
		ACT_HIGH    = 2'b10,
		ACT_TOGGLE  = 2'b11
	} ext_action_t;
	typedef logic [31:0] word_t;
endpackage : capture_match_timer_pkg
`default_nettype wire

/* prescale_if.sv */
// carrier between the timer core and its prescale counter
`timescale 1ns/10ps
`default_nettype none
interface prescale_if;
	logic [31:0] value;
	logic        run;
	logic        clear;
	logic [31:0] count;
	logic        advance;
	modport ctrl (output value, output run, output clear, input count, input advance);
	modport counter (input value, input run, input clear, output count, output advance);
endinterface : prescale_if
`default_nettype wire

/* prescale_counter.sv */
// timer clock divider and prescale counter
`timescale 1ns/10ps
`default_nettype none
`include "capture_match_timer_map.svh"
module prescale_counter
	import capture_match_timer_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	prescale_if.counter     bus
);
	logic [3:0]  div_q;
	logic        tick_q;
	logic [31:0] count_q;

	// the timer clock is a one-cycle enable derived from the bus clock
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_q  <= 4'h0;
			tick_q <= 1'b0;
		end
		else if (div_q == `TICK_DIV_LAST)
		begin
			div_q  <= 4'h0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q  <= div_q + 4'h1;
			tick_q <= 1'b0;
		end
	end

	assign bus.advance = tick_q && bus.run && !bus.clear && (count_q == bus.value);
	assign bus.count   = count_q;

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			count_q <= `COUNT_RESET;
		else if (bus.clear)
			count_q <= `COUNT_RESET;
		else if (tick_q && bus.run)
			count_q <= (count_q == bus.value) ? `COUNT_RESET : count_q + 32'h1;
	end

	chk_prescale_wrap: assert property (@(posedge i_clock) disable iff (i_rst)
		bus.advance |=> count_q == 32'h0)
		else $error("prescale counter did not wrap after advance");
	chk_prescale_step: assert property (@(posedge i_clock) disable iff (i_rst)
		(tick_q && bus.run && !bus.clear && count_q != bus.value) |=> count_q == $past(count_q) + 32'h1)
		else $error("prescale counter failed to step");
	chk_tick_spacing: assert property (@(posedge i_clock) disable iff (i_rst)
		tick_q |=> !tick_q ##1 tick_q)
		else $error("timer clock tick spacing wrong");
	chk_pause_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		(!bus.run && !bus.clear) |=> $stable(count_q))
		else $error("prescale counter moved while halted");
endmodule : prescale_counter
`default_nettype wire

/* capture_edge.sv */
// edge finder for one capture input
`timescale 1ns/10ps
`default_nettype none
module capture_edge (
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic prev_q;

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			prev_q <= 1'b0;
		else
			prev_q <= i_level;
	end

	assign o_rise = i_level && !prev_q;
	assign o_fall = !i_level && prev_q;
endmodule : capture_edge
`default_nettype wire

/* capture_match_timer.sv */
// capture/match timer: registers, timer counter, match actions, captures and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "capture_match_timer_map.svh"
module capture_match_timer
	import capture_match_timer_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_write,
	input  wire logic        i_read,
	output logic      [31:0] o_rdata,
	input  wire logic [3:0]  i_capture_input,
	input  wire logic        i_pause,
	output logic      [3:0]  o_match_output,
	output logic             o_irq
);
	prescale_if pif ();

	logic [2:0]  ctrl_q;
	logic [31:0] tc_q;
	logic [31:0] pr_q;
	logic [11:0] mcfg_q;
	logic [7:0]  ocfg_q;
	logic [11:0] ccfg_q;
	logic [31:0] match_q [4];
	logic [31:0] cap_q   [4];
	logic [7:0]  st_q;
	logic [7:0]  st_d;
	logic [7:0]  mask_q;
	logic [7:0]  mask_d;
	logic [3:0]  level_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        irq_q;
	logic [3:0]  hit;
	logic [3:0]  rise;
	logic [3:0]  fall;
	logic [3:0]  cap_ev;
	logic [3:0]  match_flag;
	logic [3:0]  cap_flag;
	logic        stop_hit;
	logic        reset_hit;
	logic        aligned;
	logic        wr_ctrl;
	logic        wr_tc;
	logic        wr_level;

	function automatic logic cfg_bit(input logic [11:0] cfg, input int unsigned ch, input int unsigned opt);
		cfg_bit = cfg[ch * `CFG_W + opt];
	endfunction : cfg_bit

	function automatic ext_action_t ext_action(input logic [7:0] cfg, input int unsigned ch);
		ext_action = ext_action_t'(cfg[ch * `OCFG_W +: `OCFG_W]);
	endfunction : ext_action

	prescale_counter u_prescale (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.bus     (pif.counter)
	);

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_capture
			capture_edge u_edge (
				.i_clock (i_clock),
				.i_rst   (i_rst),
				.i_level (i_capture_input[g]),
				.o_rise  (rise[g]),
				.o_fall  (fall[g])
			);
			assign cap_ev[g]     = (rise[g] && cfg_bit(ccfg_q, g, `CCFG_RISE))
				|| (fall[g] && cfg_bit(ccfg_q, g, `CCFG_FALL));
			assign cap_flag[g]   = cap_ev[g] && cfg_bit(ccfg_q, g, `CCFG_IRQ);
			assign hit[g]        = pif.advance && (tc_q == match_q[g]);
			assign match_flag[g] = hit[g] && cfg_bit(mcfg_q, g, `MCFG_IRQ);
		end
	endgenerate

	always_comb
	begin
		stop_hit  = 1'b0;
		reset_hit = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			stop_hit  = stop_hit || (hit[i] && cfg_bit(mcfg_q, i, `MCFG_STOP));
			reset_hit = reset_hit || (hit[i] && cfg_bit(mcfg_q, i, `MCFG_RESET));
		end
	end

	// counting only moves on timer clock ticks; register writes land on the next bus edge
	assign pif.value = pr_q;
	assign pif.run   = ctrl_q[`CTRL_ENABLE_BIT] && !(ctrl_q[`CTRL_PAUSE_EN_BIT] && i_pause);
	assign pif.clear = ctrl_q[`CTRL_CLEAR_BIT];

	assign aligned  = (i_addr[1:0] == 2'b00);
	assign wr_ctrl  = i_write && (i_addr == `REG_CTRL);
	assign wr_tc    = i_write && (i_addr == `REG_TIMER_COUNT);
	assign wr_level = i_write && (i_addr == `REG_OUTPUT_LEVEL);

	// a software write to the control register wins over a stop in the same cycle
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			ctrl_q <= `CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= i_wdata[2:0];
		else if (stop_hit)
			ctrl_q[`CTRL_ENABLE_BIT] <= 1'b0;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			tc_q <= `COUNT_RESET;
		else if (wr_tc)
			tc_q <= i_wdata;
		else if (pif.clear)
			tc_q <= `COUNT_RESET;
		else if (pif.advance)
			tc_q <= reset_hit ? `COUNT_RESET : tc_q + 32'h1;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			pr_q   <= `COUNT_RESET;
			mcfg_q <= `CFG_RESET;
			ocfg_q <= `OCFG_RESET;
			ccfg_q <= `CFG_RESET;
			mask_q <= `FLAG_RESET;
			for (int i = 0; i < 4; i++)
				match_q[i] <= `COUNT_RESET;
		end
		else if (i_write)
		begin
			if (i_addr == `REG_PRESCALE)
				pr_q <= i_wdata;
			if (i_addr == `REG_MATCH_CFG)
				mcfg_q <= i_wdata[11:0];
			if (i_addr == `REG_OUTPUT_CFG)
				ocfg_q <= i_wdata[7:0];
			if (i_addr == `REG_CAPTURE_CFG)
				ccfg_q <= i_wdata[11:0];
			mask_q <= mask_d;
			if (aligned && i_addr[7:4] == `REG_MATCH_BLOCK)
				match_q[i_addr[3:2]] <= i_wdata;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < 4; i++)
				cap_q[i] <= `COUNT_RESET;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				if (cap_ev[i])
					cap_q[i] <= tc_q;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			level_q <= `LEVEL_RESET;
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (hit[i])
				begin
					unique case (ext_action(ocfg_q, i))
						ACT_NOTHING: level_q[i] <= level_q[i];
						ACT_LOW:     level_q[i] <= 1'b0;
						ACT_HIGH:    level_q[i] <= 1'b1;
						ACT_TOGGLE:  level_q[i] <= !level_q[i];
					endcase
				end
				else if (wr_level)
					level_q[i] <= i_wdata[i];
			end
		end
	end

	// a new event in the clearing cycle survives the write-one-to-clear
	always_comb
	begin
		st_d = st_q & ~((i_write && i_addr == `REG_INT_STATUS) ? i_wdata[7:0] : 8'h00);
		st_d = st_d | {cap_flag, match_flag};
		mask_d = (i_write && i_addr == `REG_INT_MASK) ? i_wdata[7:0] : mask_q;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_q  <= `FLAG_RESET;
			irq_q <= 1'b0;
		end
		else
		begin
			st_q  <= st_d;
			irq_q <= |(st_d & mask_d);
		end
	end

	always_comb
	begin
		rdata_d = 32'h0;
		if (aligned && i_addr[7:4] == `REG_MATCH_BLOCK)
			rdata_d = match_q[i_addr[3:2]];
		else if (aligned && i_addr[7:4] == `REG_CAPTURE_BLOCK)
			rdata_d = cap_q[i_addr[3:2]];
		else
		begin
			unique case (i_addr)
				`REG_CTRL:           rdata_d = 32'(ctrl_q);
				`REG_TIMER_COUNT:    rdata_d = tc_q;
				`REG_PRESCALE:       rdata_d = pr_q;
				`REG_PRESCALE_COUNT: rdata_d = pif.count;
				`REG_MATCH_CFG:      rdata_d = 32'(mcfg_q);
				`REG_OUTPUT_CFG:     rdata_d = 32'(ocfg_q);
				`REG_OUTPUT_LEVEL:   rdata_d = 32'(level_q);
				`REG_CAPTURE_CFG:    rdata_d = 32'(ccfg_q);
				`REG_INT_STATUS:     rdata_d = 32'(st_q);
				`REG_INT_MASK:       rdata_d = 32'(mask_q);
				default:             rdata_d = 32'h0;
			endcase
		end
	end

	// read data stand for exactly one cycle after the read strobe
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			rdata_q <= 32'h0;
		else
			rdata_q <= i_read ? rdata_d : 32'h0;
	end

	assign o_rdata        = rdata_q;
	assign o_match_output = level_q;
	assign o_irq          = irq_q;

	chk_count_advance: assert property (@(posedge i_clock) disable iff (i_rst)
		(pif.advance && !reset_hit && !wr_tc) |=> tc_q == $past(tc_q) + 32'h1)
		else $error("timer count did not advance");
	chk_continuous_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		(!pif.advance && !wr_tc && !pif.clear) |=> $stable(tc_q))
		else $error("timer count moved without advance");
	chk_reset_match: assert property (@(posedge i_clock) disable iff (i_rst)
		(reset_hit && !wr_tc) |=> tc_q == 32'h0)
		else $error("reset on match did not zero count");
	chk_stop_match: assert property (@(posedge i_clock) disable iff (i_rst)
		(stop_hit && !wr_ctrl) |=> !ctrl_q[`CTRL_ENABLE_BIT] && !pif.advance)
		else $error("stop on match did not halt timer");
	chk_capture_value: assert property (@(posedge i_clock) disable iff (i_rst)
		cap_ev[0] |=> cap_q[0] == $past(tc_q))
		else $error("capture 0 missed timer count");
	chk_match_toggle: assert property (@(posedge i_clock) disable iff (i_rst)
		(hit[0] && ext_action(ocfg_q, 0) == ACT_TOGGLE) |=> o_match_output[0] != $past(o_match_output[0]))
		else $error("match output 0 did not toggle");
	chk_flag_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
		(st_q[0] && !(i_write && i_addr == `REG_INT_STATUS)) |=> st_q[0])
		else $error("pending flag dropped without clear");
	chk_irq_level: assert property (@(posedge i_clock) disable iff (i_rst)
		o_irq == |(st_q & mask_q))
		else $error("interrupt output disagrees with flags");
	// checks below tie each event to the state it must leave one bus cycle later
	chk_read_idle: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_read |=> o_rdata == 32'h0)
		else $error("read data present without a read");
	chk_clear_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		(pif.clear && !wr_tc) |=> tc_q == 32'h0)
		else $error("timer count not held at zero by clear");
	chk_continuous_run: assert property (@(posedge i_clock) disable iff (i_rst)
		(pif.advance && !stop_hit && !wr_ctrl) |=> ctrl_q[`CTRL_ENABLE_BIT])
		else $error("timer halted without a stop match");
	chk_match_flag: assert property (@(posedge i_clock) disable iff (i_rst)
		match_flag[0] |=> st_q[0])
		else $error("match 0 flag not latched");
	chk_capture_flag: assert property (@(posedge i_clock) disable iff (i_rst)
		cap_flag[0] |=> st_q[`ST_CAPTURE_LSB])
		else $error("capture 0 flag not latched");
	chk_match_low: assert property (@(posedge i_clock) disable iff (i_rst)
		(hit[0] && ext_action(ocfg_q, 0) == ACT_LOW) |=> !o_match_output[0])
		else $error("match output 0 not driven low");
	chk_match_high: assert property (@(posedge i_clock) disable iff (i_rst)
		(hit[0] && ext_action(ocfg_q, 0) == ACT_HIGH) |=> o_match_output[0])
		else $error("match output 0 not driven high");
endmodule : capture_match_timer
`default_nettype wire

/* cap_source_model.sv */
// behavioural source that drives the timer's capture inputs from bench requests
`timescale 1ns/10ps
`default_nettype none
module cap_source_model (
	input  wire logic       i_clock,
	input  wire logic [3:0] i_want,
	output logic      [3:0] o_capture
);
	// levels move only just after an edge, so each one stands for whole cycles
	initial o_capture = 4'h0;
	always @(posedge i_clock)
	begin
		o_capture <= i_want;
	end
endmodule : cap_source_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench of the capture/match timer
`timescale 1ns/10ps
`default_nettype none
`include "capture_match_timer_map.svh"
module tb_top
	import capture_match_timer_pkg::*;
;
	logic        i_clock;
	logic        i_rst;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_write;
	logic        i_read;
	logic [31:0] o_rdata;
	logic [3:0]  cap_want;
	logic [3:0]  cap_pins;
	logic        i_pause;
	logic [3:0]  o_match_output;
	logic        o_irq;
	logic [31:0] seed;
	logic [31:0] rd;
	logic [31:0] v;
	logic [31:0] lvl;
	int          num_errors;
	int          samples_checked;

	capture_match_timer u_capture_match_timer (
		.i_clock         (i_clock),
		.i_rst           (i_rst),
		.i_addr          (i_addr),
		.i_wdata         (i_wdata),
		.i_write         (i_write),
		.i_read          (i_read),
		.o_rdata         (o_rdata),
		.i_capture_input (cap_pins),
		.i_pause         (i_pause),
		.o_match_output  (o_match_output),
		.o_irq           (o_irq)
	);
	cap_source_model u_cap_source_model (
		.i_clock   (i_clock),
		.i_want    (cap_want),
		.o_capture (cap_pins)
	);

	initial i_clock = 1'b0;
	always #5 i_clock = ~i_clock;

	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : next_rand

	function automatic logic [3:0] out_expect(input logic [3:0] l, input int n, input ext_action_t a);
		logic [3:0] r;
		r = l;
		case (a)
			ACT_LOW: r[n] = 1'b0;
			ACT_HIGH: r[n] = 1'b1;
			ACT_TOGGLE: r[n] = ~l[n];
			default: r[n] = l[n];
		endcase
		return r;
	endfunction : out_expect

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		@(negedge i_clock);
		d = o_rdata;
	endtask : rd_reg

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
		logic [31:0] d;
		rd_reg(a, d);
		check(d, want);
	endtask : rd_chk

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#500000;
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		seed = 32'h7AB3;
		num_errors = 0;
		samples_checked = 0;
		i_rst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_write = 1'b0;
		i_read = 1'b0;
		cap_want = 4'h0;
		i_pause = 1'b0;
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		rd_chk(`REG_CTRL, 32'h0);
		rd_chk(`REG_TIMER_COUNT, 32'h0);
		rd_chk(`REG_INT_STATUS, 32'h0);
		rd_chk(8'h80, 32'h0);
		wr(`REG_PRESCALE, 32'hFFFF_FFFF);
		rd_chk(`REG_PRESCALE, 32'hFFFF_FFFF);
		@(negedge i_clock);
		check(o_rdata, 32'h0);
		// about 101 ticks while enabled; phase of the divider leaves one tick of slack
		for (int k = 0; k < 4; k++)
		begin
			v = next_rand() & 32'h3;
			wr(`REG_CTRL, 32'h2);
			wr(`REG_PRESCALE, v);
			wr(`REG_CTRL, 32'h1);
			repeat (200) @(posedge i_clock);
			wr(`REG_CTRL, 32'h0);
			rd_reg(`REG_TIMER_COUNT, rd);
			check(32'(rd >= 98 / (v + 1) && rd <= 102 / (v + 1)), 32'h1);
			rd_reg(`REG_PRESCALE_COUNT, rd);
			check(32'(rd <= v), 32'h1);
		end
		for (int n = 0; n < 4; n++)
			wr(8'(32'h20 + 4 * n), 32'hFFFF_FFFF);
		wr(`REG_INT_MASK, 32'hF);
		for (int n = 0; n < 4; n++)
			for (int a = 0; a < 4; a++)
			begin
				lvl = next_rand() & 32'hF;
				wr(`REG_OUTPUT_LEVEL, lvl);
				// clear both counters: a prescale count above a smaller new limit would run the long way round
				wr(`REG_CTRL, 32'h2);
				wr(`REG_PRESCALE, 32'h0);
				wr(8'(32'h20 + 4 * n), 32'h2);
				wr(`REG_MATCH_CFG, 32'h3 << (3 * n));
				wr(`REG_OUTPUT_CFG, 32'(a) << (2 * n));
				wr(`REG_CTRL, 32'h1);
				repeat (20) @(posedge i_clock);
				check({28'h0, o_match_output}, {28'h0, out_expect(lvl[3:0], n, ext_action_t'(a))});
				check({31'h0, o_irq}, 32'h1);
				rd_chk(`REG_CTRL, 32'h0);
				rd_chk(`REG_INT_STATUS, 32'h1 << n);
				wr(`REG_INT_MASK, 32'h0);
				repeat (2) @(posedge i_clock);
				check({31'h0, o_irq}, 32'h0);
				wr(`REG_INT_MASK, 32'hF);
				wr(`REG_INT_STATUS, 32'h1 << n);
				rd_chk(`REG_INT_STATUS, 32'h0);
				check({31'h0, o_irq}, 32'h0);
				wr(8'(32'h20 + 4 * n), 32'hFFFF_FFFF);
			end
		// timer frozen so the captured value is known exactly
		wr(`REG_INT_MASK, 32'hF0);
		for (int n = 0; n < 4; n++)
		begin
			v = next_rand();
			wr(`REG_TIMER_COUNT, v);
			wr(`REG_CAPTURE_CFG, 32'h5 << (3 * n));
			cap_want[n] <= 1'b1;
			repeat (4) @(posedge i_clock);
			rd_chk(8'(32'h30 + 4 * n), v);
			rd_chk(`REG_INT_STATUS, 32'h10 << n);
			check({31'h0, o_irq}, 32'h1);
			wr(`REG_INT_STATUS, 32'hFF);
			wr(`REG_TIMER_COUNT, ~v);
			cap_want[n] <= 1'b0;
			repeat (4) @(posedge i_clock);
			rd_chk(8'(32'h30 + 4 * n), v);
			rd_chk(`REG_INT_STATUS, 32'h0);
			wr(`REG_CAPTURE_CFG, 32'h6 << (3 * n));
			cap_want[n] <= 1'b1;
			repeat (4) @(posedge i_clock);
			cap_want[n] <= 1'b0;
			repeat (4) @(posedge i_clock);
			rd_chk(8'(32'h30 + 4 * n), ~v);
			rd_chk(`REG_INT_STATUS, 32'h10 << n);
			wr(`REG_INT_STATUS, 32'hFF);
		end
		// channel 0 resets the count at 5, channel 1 only flags at 3 and must not disturb counting
		wr(`REG_MATCH_CFG, 32'hC);
		wr(8'h20, 32'h5);
		wr(8'h24, 32'h3);
		wr(`REG_TIMER_COUNT, 32'h0);
		wr(`REG_CTRL, 32'h5);
		repeat (100) @(posedge i_clock);
		rd_reg(`REG_TIMER_COUNT, rd);
		check(32'(rd <= 32'h5), 32'h1);
		rd_chk(`REG_CTRL, 32'h5);
		rd_chk(`REG_INT_STATUS, 32'h2);
		check({31'h0, o_irq}, 32'h0);
		@(posedge i_clock);
		i_pause <= 1'b1;
		repeat (3) @(posedge i_clock);
		rd_reg(`REG_TIMER_COUNT, v);
		repeat (20) @(posedge i_clock);
		rd_chk(`REG_TIMER_COUNT, v);
		i_pause <= 1'b0;
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
